//--- tsp_pkg.sv
// Shared constants, types and helpers of the touch controller serial slave port.
package tsp_pkg;

    // Clock and timing: 200 MHz system clock.
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned BUS_RATE_KBPS   = 400;
    localparam int unsigned SEL_WAIT_NS     = 20;
    localparam int unsigned SEL_WAIT_CYC    = (SEL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  SEL_CNT_LATCH   = 4'(SEL_WAIT_CYC);
    localparam logic [3:0]  SEL_CNT_DONE    = 4'(SEL_WAIT_CYC + 1);

    // Slave address pairs; the low bit of the address byte selects read.
    localparam logic [7:0]  ADDR_PAIR_A_WR  = 8'hBA;
    localparam logic [7:0]  ADDR_PAIR_B_WR  = 8'h28;
    localparam logic        SEL_LVL_PAIR_B  = 1'b1;

    // Widths, depths and reset values.
    localparam int unsigned REG_ADDR_W      = 16;
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned WR_WORD_W       = REG_ADDR_W + DATA_W;
    localparam int unsigned WR_FIFO_DEPTH   = 32;
    localparam logic [15:0] PTR_RST         = 16'h0000;
    localparam logic [3:0]  BIT_LAST_RX     = 4'h8;
    localparam logic [3:0]  BIT_LAST_TX     = 4'h7;
    localparam logic [1:0]  IDX_PTR_HI      = 2'h0;
    localparam logic [1:0]  IDX_PTR_LO      = 2'h1;
    localparam logic [1:0]  IDX_DATA        = 2'h2;

    // Protocol states of the slave engine.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_RX,
        ST_RX_PUSH,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } tsp_state_e;

    // True when the address byte names the selected pair, either direction.
    function automatic logic tsp_addr_match(input logic [7:0] abyte, input logic sel_b);
        logic [7:0] base;
        base = sel_b ? ADDR_PAIR_B_WR : ADDR_PAIR_A_WR;
        return abyte[7:1] == base[7:1];
    endfunction : tsp_addr_match

endpackage : tsp_pkg

//--- tsp_fifo_if.sv
// Valid/ready carrier between the slave engine and its write FIFO.
`timescale 1ns/1ps
interface tsp_fifo_if #(parameter int unsigned W = 24);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    modport fifo (
        input  in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data
    );
    modport user (
        output in_valid, in_data, out_ready,
        input  in_ready, out_valid, out_data
    );
endinterface : tsp_fifo_if

//--- tsp_fifo.sv
// Write FIFO with a registered output stage, so the drain side sees flop outputs.
`timescale 1ns/1ps
module tsp_fifo #(
    parameter int unsigned W     = 24,
    parameter int unsigned DEPTH = 32
) (
    // Clock and reset.
    input  wire logic   clk_sys_in,
    input  wire logic   nrst_in,
    // Fill and drain sides.
    tsp_fifo_if.fifo    port_io
);
    import tsp_pkg::*;

    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0]  wptr;
        logic [AW:0]  rptr;
        logic         ovld;
        logic [W-1:0] odata;
    } tsp_fifo_s;

    tsp_fifo_s    q;
    tsp_fifo_s    d;
    logic [W-1:0] mem [DEPTH];
    logic         full;
    logic         push;

    // Full when the pointers differ by exactly the depth.
    assign full              = (q.wptr - q.rptr) == (AW + 1)'(DEPTH);
    assign push              = port_io.in_valid && !full;
    assign port_io.in_ready  = !full;
    assign port_io.out_valid = q.ovld;
    assign port_io.out_data  = q.odata;

    // Output stage refills whenever it is empty or being drained this cycle.
    always_comb begin
        d = q;
        if (push) begin
            d.wptr = q.wptr + (AW + 1)'(1);
        end
        if ((!q.ovld || port_io.out_ready) && (q.wptr != q.rptr)) begin
            d.odata = mem[q.rptr[AW-1:0]];
            d.rptr  = q.rptr + (AW + 1)'(1);
            d.ovld  = 1'b1;
        end else if (port_io.out_ready) begin
            d.ovld  = 1'b0;
        end
    end

    // Storage array holds no reset; only the pointers matter after reset.
    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem[q.wptr[AW-1:0]] <= port_io.in_data;
        end
    end

    // State register.
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : tsp_fifo

//--- tsp_i2c_slave.sv
// Two-wire slave port with 16-bit register pointer, sequential access and write FIFO.
//
// Behaviour
// - Slave only; master clocks all transfers.
// - Answer address pair BA/BB or 28/29.
// - Active-low reset holds all state idle.
// - Data falling while clock high starts.
// - Data rising while clock high stops.
// - Matching address byte acknowledged low, ninth clock.
// - Mismatching address: no acknowledge, back idle.
// - Every byte is eight bits plus acknowledge.
// - Data driven changes only while clock low.
// - Pointer increments after every written data byte.
// - Read: pointer write, repeated start, read address.
// - Sequential read advances pointer while master acknowledges.
`timescale 1ns/1ps
module tsp_i2c_slave (
    // Clock and reset.
    input  wire logic                           clk_sys_in,
    input  wire logic                           nrst_in,
    // Serial clock pin, open drain, driven only for clock stretching.
    input  wire logic                           scl_in,
    output logic                                scl_out,
    output logic                                scl_oe_out,
    // Serial data pin, open drain.
    input  wire logic                           sda_in,
    output logic                                sda_out,
    output logic                                sda_oe_out,
    // Interrupt pin level, sampled after reset release for address selection.
    input  wire logic                           int_in,
    output logic                                addr_sel_b_out,
    // Read side: data must follow rd_addr_out within the same cycle.
    output logic [tsp_pkg::REG_ADDR_W-1:0]      rd_addr_out,
    input  wire logic [tsp_pkg::DATA_W-1:0]     rd_data_in,
    // Write stream from the FIFO.
    output logic                                wr_valid_out,
    input  wire logic                           wr_ready_in,
    output logic [tsp_pkg::REG_ADDR_W-1:0]      wr_addr_out,
    output logic [tsp_pkg::DATA_W-1:0]          wr_data_out
);
    import tsp_pkg::*;

    typedef struct packed {
        tsp_state_e  st;
        logic [2:0]  scl_s;
        logic [2:0]  sda_s;
        logic [2:0]  int_s;
        logic        scl_f;
        logic        sda_f;
        logic        int_f;
        logic [3:0]  sel_cnt;
        logic        sel_b;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic [15:0] ptr;
        logic [1:0]  idx;
        logic        is_read;
        logic        m_ack;
        logic        sda_oe;
        logic        scl_oe;
        logic        pin_lo;
    } tsp_slave_s;

    tsp_slave_s q;
    tsp_slave_s d;
    logic       scl_rise;
    logic       scl_fall;
    logic       sda_rise;
    logic       sda_fall;
    logic       ev_start;
    logic       ev_stop;
    logic       sel_done;
    logic       push_go;

    tsp_fifo_if #(.W(WR_WORD_W)) wr_if ();

    tsp_fifo #(
        .W     (WR_WORD_W),
        .DEPTH (WR_FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .port_io    (wr_if.fifo)
    );

    // Filtered edges: a pin level counts once the second and third stages agree.
    assign scl_rise = (q.scl_s[1] == q.scl_s[2]) && q.scl_s[2] && !q.scl_f;
    assign scl_fall = (q.scl_s[1] == q.scl_s[2]) && !q.scl_s[2] && q.scl_f;
    assign sda_rise = (q.sda_s[1] == q.sda_s[2]) && q.sda_s[2] && !q.sda_f;
    assign sda_fall = (q.sda_s[1] == q.sda_s[2]) && !q.sda_s[2] && q.sda_f;
    assign sel_done = (q.sel_cnt == SEL_CNT_DONE);
    // Start and stop need a steady high clock; start is ignored until the pair is chosen.
    assign ev_start = sel_done && sda_fall && q.scl_f && !scl_fall;
    assign ev_stop  = sda_rise && q.scl_f && !scl_fall;
    // Pointer bytes never stall; data bytes wait for FIFO room.
    assign push_go  = (q.idx != IDX_DATA) || wr_if.in_ready;

    // FIFO fill side: a stalled push holds the serial clock low.
    assign wr_if.in_valid  = (q.st == ST_RX_PUSH) && (q.idx == IDX_DATA);
    assign wr_if.in_data   = {q.ptr, q.sh};
    assign wr_if.out_ready = wr_ready_in;

    // All pin and user outputs are flops.
    assign scl_out        = q.pin_lo;
    assign sda_out        = q.pin_lo;
    assign scl_oe_out     = q.scl_oe;
    assign sda_oe_out     = q.sda_oe;
    assign addr_sel_b_out = q.sel_b;
    assign rd_addr_out    = q.ptr;
    assign wr_valid_out   = wr_if.out_valid;
    assign wr_addr_out    = wr_if.out_data[WR_WORD_W-1:DATA_W];
    assign wr_data_out    = wr_if.out_data[DATA_W-1:0];

    // Next-state logic of the whole engine.
    always_comb begin
        d = q;
        d.scl_s = {q.scl_s[1:0], scl_in};
        d.sda_s = {q.sda_s[1:0], sda_in};
        d.int_s = {q.int_s[1:0], int_in};
        if (q.scl_s[1] == q.scl_s[2]) begin
            d.scl_f = q.scl_s[2];
        end
        if (q.sda_s[1] == q.sda_s[2]) begin
            d.sda_f = q.sda_s[2];
        end
        if (q.int_s[1] == q.int_s[2]) begin
            d.int_f = q.int_s[2];
        end
        // Pair selection is caught once, shortly after reset release.
        if (!sel_done) begin
            d.sel_cnt = q.sel_cnt + 4'h1;
            if (q.sel_cnt == SEL_CNT_LATCH) begin
                d.sel_b = (q.int_f == SEL_LVL_PAIR_B);
            end
        end
        if (ev_start) begin
            // Repeated start keeps the pointer so a read can follow a pointer write.
            d.st     = ST_ADDR;
            d.cnt    = 4'h0;
            d.idx    = IDX_PTR_HI;
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
        end else if (ev_stop) begin
            d.st     = ST_IDLE;
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
        end else begin
            case (q.st)
                ST_IDLE: begin
                    d.sda_oe = 1'b0;
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise && (q.cnt < BIT_LAST_RX)) begin
                        d.sh  = {q.sh[6:0], q.sda_f};
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && (q.cnt == BIT_LAST_RX)) begin
                        if (q.st == ST_RX) begin
                            d.st = ST_RX_PUSH;
                        end else if (tsp_addr_match(q.sh, q.sel_b)) begin
                            d.st      = ST_ACK_ADDR;
                            d.sda_oe  = 1'b1;
                            d.is_read = q.sh[0];
                        end else begin
                            d.st = ST_IDLE;
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        d.cnt = 4'h0;
                        if (q.is_read) begin
                            d.st     = ST_TX;
                            d.sh     = rd_data_in;
                            d.sda_oe = !rd_data_in[7];
                            d.ptr    = q.ptr + 16'h0001;
                        end else begin
                            d.st     = ST_RX;
                            d.sda_oe = 1'b0;
                        end
                    end
                end
                ST_RX_PUSH: begin
                    // Clock stretching is the only time the clock line is driven.
                    if (push_go) begin
                        d.st     = ST_RX_ACK;
                        d.sda_oe = 1'b1;
                        d.scl_oe = 1'b0;
                        case (q.idx)
                            IDX_PTR_HI: d.ptr[15:8] = q.sh;
                            IDX_PTR_LO: d.ptr[7:0]  = q.sh;
                            default:    d.ptr       = q.ptr + 16'h0001;
                        endcase
                        if (q.idx != IDX_DATA) begin
                            d.idx = q.idx + 2'h1;
                        end
                    end else begin
                        d.scl_oe = 1'b1;
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        d.st     = ST_RX;
                        d.sda_oe = 1'b0;
                        d.cnt    = 4'h0;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (q.cnt == BIT_LAST_TX) begin
                            d.st     = ST_TX_ACK;
                            d.sda_oe = 1'b0;
                        end else begin
                            d.sh     = {q.sh[6:0], 1'b0};
                            d.sda_oe = !q.sh[6];
                            d.cnt    = q.cnt + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        d.m_ack = !q.sda_f;
                    end else if (scl_fall) begin
                        d.cnt = 4'h0;
                        if (q.m_ack) begin
                            d.st     = ST_TX;
                            d.sh     = rd_data_in;
                            d.sda_oe = !rd_data_in[7];
                            d.ptr    = q.ptr + 16'h0001;
                        end else begin
                            d.st     = ST_IDLE;
                            d.sda_oe = 1'b0;
                        end
                    end
                end
                default: begin
                    d.st     = ST_IDLE;
                    d.sda_oe = 1'b0;
                    d.scl_oe = 1'b0;
                end
            endcase
        end
    end

    // State register; synchronous active-low reset.
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            // Clock and data filters start at the idle-high bus level, so release gives no false edge.
            q       <= '0;
            q.scl_s <= 3'h7;
            q.sda_s <= 3'h7;
            q.scl_f <= 1'b1;
            q.sda_f <= 1'b1;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);

    // Reset drops every driver and returns the engine to idle.
    a_reset_idle: assert property (disable iff (1'b0)
        !nrst_in |=> (q.st == ST_IDLE) && !sda_oe_out && !scl_oe_out && (q.ptr == PTR_RST))
        else $error("Reset did not idle the port.");

    // The clock line is only ever pulled during a stalled data push.
    a_slave_only_clk: assert property (
        scl_oe_out |-> ($past(q.st) == ST_RX_PUSH) && !$past(push_go))
        else $error("Clock driven outside a stall.");

    // The pair choice is the interrupt level seen at the latch cycle, then frozen.
    a_sel_latched: assert property (
        (q.sel_cnt == SEL_CNT_LATCH) |=> (q.sel_b == ($past(q.int_f) == SEL_LVL_PAIR_B))
            ##1 $stable(q.sel_b)[*8])
        else $error("Address pair not latched from interrupt level.");

    a_start_seen: assert property (
        ev_start |=> (q.st == ST_ADDR) && (q.cnt == 4'h0) && !sda_oe_out)
        else $error("Start not taken.");

    a_stop_seen: assert property (
        ev_stop |=> (q.st == ST_IDLE) && !sda_oe_out)
        else $error("Stop not taken.");

    // A matching address is acknowledged low until the end of the ninth clock.
    a_addr_ack: assert property (
        ((q.st == ST_ADDR) && scl_fall && (q.cnt == BIT_LAST_RX) && tsp_addr_match(q.sh, q.sel_b)
            && !ev_start && !ev_stop) |=> sda_oe_out && (q.st == ST_ACK_ADDR))
        else $error("Matching address not acknowledged.");

    a_addr_nomatch: assert property (
        ((q.st == ST_ADDR) && scl_fall && (q.cnt == BIT_LAST_RX) && !tsp_addr_match(q.sh, q.sel_b)
            && !ev_start && !ev_stop) |=> !sda_oe_out && (q.st == ST_IDLE))
        else $error("Foreign address answered.");

    a_nine_bits: assert property (
        ((q.st == ST_RX) && (q.cnt == BIT_LAST_RX) && !scl_rise && scl_fall && !ev_start
            && !ev_stop) |=> (q.st == ST_RX_PUSH) && !sda_oe_out)
        else $error("Byte boundary not after eight bits.");

    // Our data driver moves only after the filtered clock has gone low.
    a_sda_clk_low: assert property (
        ($changed(sda_oe_out) && !$past(ev_start) && !$past(ev_stop)) |-> !$past(scl_in, 4)
            || !q.scl_f)
        else $error("Data driver changed while clock high.");

    a_wr_ptr_inc: assert property (
        (wr_if.in_valid && wr_if.in_ready && !ev_start && !ev_stop) |=>
            (q.ptr == $past(q.ptr) + 16'h0001))
        else $error("Pointer not advanced after write.");

    a_rd_ptr_inc: assert property (
        ((q.st == ST_TX_ACK) && scl_fall && q.m_ack && !ev_start && !ev_stop) |=>
            (q.ptr == $past(q.ptr) + 16'h0001) && (q.st == ST_TX))
        else $error("Sequential read did not advance.");

    a_nack_release: assert property (
        ((q.st == ST_TX_ACK) && scl_fall && !q.m_ack && !ev_start) |=>
            !sda_oe_out && (q.st == ST_IDLE))
        else $error("Data line not released after not-acknowledge.");

    c_write_push: cover property (wr_if.in_valid && wr_if.in_ready);
    c_stall: cover property (scl_oe_out ##1 !scl_oe_out);
    c_seq_read: cover property ((q.st == ST_TX_ACK) && scl_fall && q.m_ack);
    c_nack_end: cover property ((q.st == ST_TX_ACK) && scl_fall && !q.m_ack);

endmodule : tsp_i2c_slave

//--- tsp_host_model.sv
// Behavioural two-wire bus master that drives the slave port in the bench.
`timescale 1ns/1ps
module tsp_host_model (
    // Wired bus levels.
    input  wire logic scl_in,
    input  wire logic sda_in,
    // Pull-down enables of the master, high while pulling low.
    output logic      scl_oe_out,
    output logic      sda_oe_out
);
    // Quarter of a 64 ns bus period; the master clocks every transfer.
    localparam time QTR = 16;

    // Lines start released, so the pull-ups hold both high.
    initial begin
        scl_oe_out = 1'b0;
        sda_oe_out = 1'b0;
    end

    // Start and repeated start: data falls while the clock is high.
    // Data is let go a quarter period before the clock rises, so a slave that still
    // holds its acknowledge has released it first; otherwise a stop would be seen.
    task automatic start_c();
        #QTR sda_oe_out = 1'b0;
        #QTR scl_oe_out = 1'b0;
        #QTR sda_oe_out = 1'b1;
        #QTR scl_oe_out = 1'b1;
    endtask : start_c

    // Stop: data rises while the clock is high.
    task automatic stop_c();
        #QTR sda_oe_out = 1'b1;
        #QTR scl_oe_out = 1'b0;
        #QTR sda_oe_out = 1'b0;
        #QTR;
    endtask : stop_c

    // One clock; data moves only while the clock is low.
    task automatic bit_c(input logic b, output logic s);
        #QTR sda_oe_out = ~b;
        #QTR scl_oe_out = 1'b0;
        // A stretching slave holds the clock low; the wait is bounded.
        for (int n = 0; n < 400000 && scl_in !== 1'b1; n++) #1;
        #QTR s = sda_in;
        #QTR scl_oe_out = 1'b1;
    endtask : bit_c

    // Eight bits MSB first, then the slave's acknowledge slot.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) bit_c(b[i], ack);
        bit_c(1'b1, ack);
    endtask : send_byte

    // Eight bits read, then our acknowledge, or not for the last byte.
    task automatic get_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_c(1'b1, d[i]);
        bit_c(nack, s);
    endtask : get_byte

    // Lets go of both lines, used around a reset.
    task automatic release_all();
        sda_oe_out = 1'b0;
        scl_oe_out = 1'b0;
    endtask : release_all
endmodule : tsp_host_model

//--- tsp_i2c_slave_bench.sv
// Self-checking bench of the serial slave port with a behavioural bus master.
`timescale 1ns/1ps
`define CHK(NM, E, G) begin checks++; if ((E) !== (G)) begin fails++; $display("BAD %s exp %0h seen %0h", NM, E, G); end end
module tsp_i2c_slave_bench;
    import tsp_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        int_pin = 1'b0;
    logic        wr_ready = 1'b0;
    logic        hold = 1'b0;
    logic        stretched = 1'b0;
    logic        scl_line, sda_line, m_scl, m_sda;
    logic        scl_o, scl_oe, sda_o, sda_oe, sel_b, wr_valid;
    logic [15:0] rd_addr, wr_addr;
    logic [7:0]  rd_data, wr_data;
    logic [23:0] w;
    logic [23:0] expq[$];
    int          fails = 0;
    int          checks = 0;
    int          cyc = 0;

    // Wired-AND bus with pull-ups: any pulling party wins.
    assign scl_line = !(m_scl || (scl_oe && !scl_o));
    assign sda_line = !(m_sda || (sda_oe && !sda_o));
    assign rd_data  = mem_f(rd_addr);

    always #2.5 clk = ~clk;

    // Stand-in register contents seen by the read side.
    function automatic logic [7:0] mem_f(input logic [15:0] a);
        return a[15:8] ^ a[7:0] ^ 8'h5A;
    endfunction : mem_f

    tsp_i2c_slave dut (
        .clk_sys_in(clk), .nrst_in(nrst), .scl_in(scl_line), .scl_out(scl_o),
        .scl_oe_out(scl_oe), .sda_in(sda_line), .sda_out(sda_o), .sda_oe_out(sda_oe),
        .int_in(int_pin), .addr_sel_b_out(sel_b), .rd_addr_out(rd_addr),
        .rd_data_in(rd_data), .wr_valid_out(wr_valid), .wr_ready_in(wr_ready),
        .wr_addr_out(wr_addr), .wr_data_out(wr_data)
    );

    tsp_host_model mst (
        .scl_in(scl_line), .sda_in(sda_line), .scl_oe_out(m_scl), .sda_oe_out(m_sda)
    );

    // Random stalls of the consumer; hold keeps it stalled to fill the FIFO.
    always @(negedge clk) begin
        wr_ready <= hold ? 1'b0 : 1'(($urandom & 3) != 0);
    end

    // Consumer side: each taken word is checked against the oldest note.
    always @(posedge clk) begin
        if (nrst && wr_valid && wr_ready) begin
            w = (expq.size() != 0) ? expq.pop_front() : 'x;
            `CHK("wr_word", w, {wr_addr, wr_data})
        end
        if (scl_oe) stretched <= 1'b1;
        cyc++;
        if (cyc == 30000) begin
            fails++;
            stop_test();
        end
    end

    // Reset with the interrupt pin at the selecting level.
    task automatic do_reset(input logic sel);
        @(negedge clk);
        nrst = 1'b0;
        int_pin = sel;
        mst.release_all();
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (12) @(negedge clk);
        // The pin is free again; the selection must stay latched.
        int_pin = ~sel;
        `CHK("sel", sel, sel_b)
        `CHK("ptr", PTR_RST, rd_addr)
    endtask : do_reset

    // Start, write address and 16-bit pointer, high byte first.
    task automatic addr_ptr(input logic [7:0] a, input logic [15:0] p);
        logic ack;
        mst.start_c();
        mst.send_byte(a, ack);
        `CHK("ack_addr", 1'b0, ack)
        mst.send_byte(p[15:8], ack);
        `CHK("ack_hi", 1'b0, ack)
        mst.send_byte(p[7:0], ack);
        `CHK("ack_lo", 1'b0, ack)
    endtask : addr_ptr

    task automatic wr_xfer(input logic [7:0] a, input logic [15:0] p, input int n);
        logic ack;
        logic [7:0] d;
        addr_ptr(a, p);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            expq.push_back({16'(p + i), d});
            mst.send_byte(d, ack);
            `CHK("ack_data", 1'b0, ack)
        end
        mst.stop_c();
    endtask : wr_xfer

    task automatic rd_xfer(input logic [7:0] a, input logic [15:0] p, input int n);
        logic ack;
        logic [7:0] d;
        addr_ptr(a, p);
        mst.start_c();
        mst.send_byte(a | 8'h01, ack);
        `CHK("ack_rd", 1'b0, ack)
        for (int i = 0; i < n; i++) begin
            mst.get_byte(i == n - 1, d);
            `CHK("rd_byte", mem_f(16'(p + i)), d)
        end
        #40;
        `CHK("sda_free", 1'b0, sda_oe)
        mst.stop_c();
    endtask : rd_xfer

    // Foreign address: no acknowledge, and no answer until a new start.
    task automatic bad_addr(input logic [7:0] a);
        logic ack;
        mst.start_c();
        mst.send_byte(a, ack);
        `CHK("nack_addr", 1'b1, ack)
        mst.send_byte(a ^ 8'h92, ack);
        `CHK("idle", 1'b1, ack)
        mst.stop_c();
    endtask : bad_addr

    task automatic drain();
        for (int n = 0; n < 4000 && expq.size() != 0; n++) @(negedge clk);
        `CHK("drained", 0, expq.size())
    endtask : drain

    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    // Main sequence: pair A traffic, FIFO fill, then reset into pair B.
    initial begin
        logic ack;
        void'($urandom(32'hE8EF));
        do_reset(1'b0);
        wr_xfer(ADDR_PAIR_A_WR, 16'hFFFE, 4);
        rd_xfer(ADDR_PAIR_A_WR, 16'h12FF, 3);
        bad_addr(ADDR_PAIR_B_WR);
        hold = 1'b1;
        fork
            wr_xfer(ADDR_PAIR_A_WR, 16'($urandom), 40);
            #25000 hold = 1'b0;
        join
        `CHK("stretch", 1'b1, stretched)
        drain();
        mst.start_c();
        mst.send_byte(ADDR_PAIR_A_WR, ack);
        do_reset(1'b1);
        bad_addr(ADDR_PAIR_A_WR);
        wr_xfer(ADDR_PAIR_B_WR, 16'h0040, 2);
        rd_xfer(ADDR_PAIR_B_WR, 16'h0040, 2);
        drain();
        stop_test();
    end
endmodule : tsp_i2c_slave_bench
